/* flash_syscall_pkg.sv */
// Constants, types and register map of the flash row write and erase system-call sequencer
// Operation
// - Write row erases then programs row
// - All-zero page latch skips programming
// - Page latch cleared after programming
// - Write and program row never alter write-protected rows
// - Write row switches fast oscillator off
// - Program row programs without erasing
// - Row number in parameter bits 31:16
// - Erase all clears code and protection
// - Erase all request only debug, programming, open
// - Protected to open triggers erase all
package flash_syscall_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_ARGUMENT = 4'h0;
    localparam logic [ADDR_W-1:0] REG_REQUEST = 4'h4;
    localparam logic [ADDR_W-1:0] REG_OSC_CONTROL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;

    localparam logic [31:0] ARGUMENT_RESET = 32'h0000_0000;
    localparam logic [31:0] REQUEST_RESET = 32'h0000_0000;
    localparam logic [1:0] OSC_CONTROL_RESET = 2'h1;

    localparam int KEY_FIRST_LSB = 0;
    localparam int KEY_SECOND_LSB = 8;
    localparam int ROW_LSB = 16;
    localparam int OPCODE_LSB = 0;
    localparam int REQUEST_TRIGGER_BIT = 31;
    localparam int STATUS_LSB = 28;
    localparam int OSC_ENABLE_BIT = 0;
    localparam int PUMP_SELECT_BIT = 1;

    localparam logic [7:0] FIRST_KEY = 8'hb6;
    localparam logic [7:0] SECOND_KEY_WRITE_ROW = 8'hd8;
    localparam logic [7:0] SECOND_KEY_PROGRAM_ROW = 8'hd9;
    localparam logic [7:0] SECOND_KEY_ERASE_ALL = 8'hdd;
    localparam logic [15:0] OPCODE_WRITE_ROW = 16'h0005;
    localparam logic [15:0] OPCODE_PROGRAM_ROW = 16'h0006;
    localparam logic [15:0] OPCODE_ERASE_ALL = 16'h000a;

    localparam logic [3:0] STATUS_SUCCESS = 4'ha;
    localparam logic [3:0] STATUS_FAILURE = 4'hf;

    localparam logic [7:0] PROTECTION_OPEN = 8'h01;
    localparam logic [7:0] PROTECTION_PROTECTED = 8'h02;

    localparam int ROW_BYTES = 128;
    localparam int BYTE_INDEX_W = $clog2(ROW_BYTES);

    typedef enum logic [1:0] {
        FLASH_NONE = 2'b00,
        FLASH_ERASE_ROW = 2'b01,
        FLASH_PROGRAM_ROW = 2'b10,
        FLASH_ERASE_ALL = 2'b11
    } flash_op_t;

    typedef struct packed {
        logic start;
        flash_op_t op;
        logic [15:0] row;
    } flash_cmd_t;

    typedef struct packed {
        logic valid;
        logic [BYTE_INDEX_W-1:0] index;
        logic [7:0] data;
    } latch_byte_t;
endpackage : flash_syscall_pkg

/* page_latch_buffer.sv */
// Page latch buffer: byte memory with per-byte written marks and a one-cycle clear
`timescale 1ns/1ps
module page_latch_buffer #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic loadEn, // Byte load strobe
    input wire logic [$clog2(DEPTH)-1:0] loadIndex, // Byte position to load
    input wire logic [WIDTH-1:0] loadData, // Byte value to load
    input wire logic readEn, // Read strobe
    input wire logic [$clog2(DEPTH)-1:0] readIndex, // Byte position to read
    input wire logic clear, // Empty the whole buffer
    output logic readValid, // Read data valid, one cycle after readEn
    output logic [$clog2(DEPTH)-1:0] readIndexOut, // Position of the byte on readData
    output logic [WIDTH-1:0] readData, // Registered read data
    output logic anyNonZero // Some loaded byte is not zero
);
    localparam int IDX_W = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << IDX_W) != DEPTH) begin
            $error("page_latch_buffer: DEPTH must be a power of two");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [DEPTH-1:0] written;

    always_ff @(posedge clk) begin
        if (loadEn) begin
            mem[loadIndex] <= loadData;
        end
    end

    // A load in the clearing cycle survives for its own byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            written <= '0;
        end else begin
            if (clear) begin
                written <= '0;
            end
            if (loadEn) begin
                written[loadIndex] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            anyNonZero <= 1'b0;
        end else if (loadEn && loadData != '0) begin
            anyNonZero <= 1'b1;
        end else if (clear) begin
            anyNonZero <= 1'b0;
        end
    end

    // Cleared bytes read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readValid <= 1'b0;
            readIndexOut <= '0;
            readData <= '0;
        end else begin
            readValid <= readEn;
            if (readEn) begin
                readIndexOut <= readIndex;
                readData <= written[readIndex] ? mem[readIndex] : '0;
            end
        end
    end
endmodule : page_latch_buffer

/* protection_watch.sv */
// Chip protection tracker: open level and protected-to-open transition pulse
`timescale 1ns/1ps
module protection_watch
    import flash_syscall_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [7:0] chipProtection, // Current chip protection mode
    output logic chipOpen, // Chip is in open mode
    output logic openedPulse // One-cycle pulse on protected to open
);
    logic [7:0] lastProtection;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastProtection <= PROTECTION_OPEN;
            chipOpen <= 1'b0;
            openedPulse <= 1'b0;
        end else begin
            lastProtection <= chipProtection;
            chipOpen <= (chipProtection == PROTECTION_OPEN);
            openedPulse <= (lastProtection == PROTECTION_PROTECTED) && (chipProtection == PROTECTION_OPEN);
        end
    end
endmodule : protection_watch

/* flash_row_write_erase_syscall.sv */
// System-call sequencer for write row, program row and erase all flash requests
`timescale 1ns/1ps
module flash_row_write_erase_syscall
    import flash_syscall_pkg::*;
(
    input wire logic ref_clk, // System clock, 20 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] regAddr, // Register byte address
    input wire logic [31:0] regWdata, // Register write data
    input wire logic regWrite, // Register write strobe
    input wire logic regRead, // Register read strobe
    output logic [31:0] regRdata, // Read data, cycle after regRead
    output logic sramReq, // Parameter word read request pulse
    output logic [31:0] sramAddr, // Word-aligned parameter address
    input wire logic sramValid, // Parameter word returned
    input wire logic [31:0] sramRdata, // Parameter word data
    input wire logic callerIsDebug, // Current caller is the debug access port
    input wire logic programmingMode, // Device is in programming mode
    input wire logic [7:0] chipProtection, // Chip protection mode
    input wire logic rowProtected, // Row on flashCmd.row is write protected
    input wire logic latchLoadEn, // Page latch byte load strobe
    input wire logic [BYTE_INDEX_W-1:0] latchLoadIndex, // Page latch byte position
    input wire logic [7:0] latchLoadData, // Page latch byte value
    output flash_cmd_t flashCmd, // Flash array command
    input wire logic flashDone, // Flash array operation finished pulse
    output latch_byte_t programByte, // Row data stream to the flash array
    output logic fastOscOutputEnable, // Fast oscillator output enable
    output logic pumpClockSelect // Pump clock select
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_FETCH = 4'h1,
        S_WAIT_PARAM = 4'h2,
        S_DECODE = 4'h3,
        S_OSC_OFF = 4'h4,
        S_ERASE_GO = 4'h5,
        S_ERASE_WAIT = 4'h6,
        S_PROG_CHECK = 4'h7,
        S_STREAM = 4'h8,
        S_PROG_GO = 4'h9,
        S_PROG_WAIT = 4'ha,
        S_CLEAR = 4'hb,
        S_ERASE_ALL_GO = 4'hc,
        S_ERASE_ALL_WAIT = 4'hd,
        S_FINISH = 4'he
    } seq_state_t;

    seq_state_t state;
    logic [31:0] argument;
    logic [31:0] request;
    logic [1:0] oscControl;
    logic [31:0] paramWord;
    logic [3:0] resultCode;
    logic [3:0] lastResult;
    logic fromRequest;
    logic erasePending;
    logic [BYTE_INDEX_W-1:0] streamIndex;
    logic chipOpen;
    logic openedPulse;
    logic latchClear;
    logic latchRead;
    logic latchAnyNonZero;
    logic writeArgument;
    logic writeRequest;
    logic writeOsc;
    logic [15:0] reqOpcode;
    logic [7:0] keyFirst;
    logic [7:0] keySecond;
    logic eraseAllAllowed;

    function automatic logic [7:0] field8(input logic [31:0] word, input int lsb);
        field8 = word[lsb +: 8];
    endfunction : field8

    assign writeArgument = regWrite && regAddr == REG_ARGUMENT;
    assign writeRequest = regWrite && regAddr == REG_REQUEST;
    assign writeOsc = regWrite && regAddr == REG_OSC_CONTROL;
    assign reqOpcode = request[OPCODE_LSB +: 16];
    assign keyFirst = field8(paramWord, KEY_FIRST_LSB);
    assign keySecond = field8(paramWord, KEY_SECOND_LSB);
    assign eraseAllAllowed = callerIsDebug && programmingMode && chipOpen;
    assign latchClear = state == S_CLEAR;
    assign latchRead = state == S_STREAM;

    page_latch_buffer #(
        .DEPTH(ROW_BYTES),
        .WIDTH(8)
    ) latch (
        .clk(ref_clk),
        .rst_n(rst_n),
        .loadEn(latchLoadEn),
        .loadIndex(latchLoadIndex),
        .loadData(latchLoadData),
        .readEn(latchRead),
        .readIndex(streamIndex),
        .clear(latchClear),
        .readValid(programByte.valid),
        .readIndexOut(programByte.index),
        .readData(programByte.data),
        .anyNonZero(latchAnyNonZero)
    );

    protection_watch protect (
        .clk(ref_clk),
        .rst_n(rst_n),
        .chipProtection(chipProtection),
        .chipOpen(chipOpen),
        .openedPulse(openedPulse)
    );

    // Sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            resultCode <= STATUS_SUCCESS;
            fromRequest <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (erasePending) begin
                        fromRequest <= 1'b0;
                        state <= S_ERASE_ALL_GO;
                    end else if (request[REQUEST_TRIGGER_BIT]) begin
                        fromRequest <= 1'b1;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    state <= S_WAIT_PARAM;
                end
                S_WAIT_PARAM: begin
                    if (sramValid) begin
                        state <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    resultCode <= STATUS_FAILURE;
                    state <= S_FINISH;
                    if (keyFirst == FIRST_KEY) begin
                        if (reqOpcode == OPCODE_WRITE_ROW && keySecond == SECOND_KEY_WRITE_ROW) begin
                            if (!rowProtected) begin
                                resultCode <= STATUS_SUCCESS;
                                state <= S_OSC_OFF;
                            end
                        end else if (reqOpcode == OPCODE_PROGRAM_ROW && keySecond == SECOND_KEY_PROGRAM_ROW) begin
                            if (!rowProtected) begin
                                resultCode <= STATUS_SUCCESS;
                                state <= S_PROG_CHECK;
                            end
                        end else if (reqOpcode == OPCODE_ERASE_ALL && keySecond == SECOND_KEY_ERASE_ALL) begin
                            if (eraseAllAllowed) begin
                                resultCode <= STATUS_SUCCESS;
                                state <= S_ERASE_ALL_GO;
                            end
                        end
                    end
                end
                S_OSC_OFF: begin
                    state <= S_ERASE_GO;
                end
                S_ERASE_GO: begin
                    state <= S_ERASE_WAIT;
                end
                S_ERASE_WAIT: begin
                    if (flashDone) begin
                        state <= S_PROG_CHECK;
                    end
                end
                S_PROG_CHECK: begin
                    state <= latchAnyNonZero ? S_STREAM : S_CLEAR;
                end
                S_STREAM: begin
                    if (streamIndex == BYTE_INDEX_W'(ROW_BYTES - 1)) begin
                        state <= S_PROG_GO;
                    end
                end
                S_PROG_GO: begin
                    state <= S_PROG_WAIT;
                end
                S_PROG_WAIT: begin
                    if (flashDone) begin
                        state <= S_CLEAR;
                    end
                end
                S_CLEAR: begin
                    state <= S_FINISH;
                end
                S_ERASE_ALL_GO: begin
                    state <= S_ERASE_ALL_WAIT;
                end
                S_ERASE_ALL_WAIT: begin
                    if (flashDone) begin
                        state <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Byte position streamed from the page latch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            streamIndex <= '0;
        end else if (state == S_STREAM) begin
            streamIndex <= streamIndex + BYTE_INDEX_W'(1);
        end else begin
            streamIndex <= '0;
        end
    end

    // Parameter word fetch from SRAM
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sramReq <= 1'b0;
            sramAddr <= 32'h0000_0000;
            paramWord <= 32'h0000_0000;
        end else begin
            sramReq <= state == S_IDLE && !erasePending && request[REQUEST_TRIGGER_BIT];
            if (state == S_IDLE) begin
                sramAddr <= {argument[31:2], 2'b00};
            end
            if (state == S_WAIT_PARAM && sramValid) begin
                paramWord <= sramRdata;
            end
        end
    end

    // Flash array commands
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flashCmd <= '{start: 1'b0, op: FLASH_NONE, row: 16'h0000};
        end else begin
            flashCmd.start <= 1'b0;
            if (state == S_WAIT_PARAM && sramValid) begin
                flashCmd.row <= sramRdata[ROW_LSB +: 16];
            end
            unique case (state)
                S_ERASE_GO: begin
                    flashCmd.start <= 1'b1;
                    flashCmd.op <= FLASH_ERASE_ROW;
                end
                S_PROG_GO: begin
                    flashCmd.start <= 1'b1;
                    flashCmd.op <= FLASH_PROGRAM_ROW;
                end
                S_ERASE_ALL_GO: begin
                    flashCmd.start <= 1'b1;
                    flashCmd.op <= FLASH_ERASE_ALL;
                end
                default: begin
                end
            endcase
        end
    end

    // Automatic erase after leaving protected mode; a new transition wins over the take-up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            erasePending <= 1'b0;
        end else if (openedPulse) begin
            erasePending <= 1'b1;
        end else if (state == S_IDLE) begin
            erasePending <= 1'b0;
        end
    end

    // Fast oscillator output and pump select; the sequencer switches them off before a write-row erase, not before erase all
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oscControl <= OSC_CONTROL_RESET;
        end else if (state == S_OSC_OFF) begin
            oscControl <= 2'h0;
        end else if (writeOsc) begin
            oscControl <= regWdata[1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastOscOutputEnable <= OSC_CONTROL_RESET[OSC_ENABLE_BIT];
            pumpClockSelect <= OSC_CONTROL_RESET[PUMP_SELECT_BIT];
        end else begin
            fastOscOutputEnable <= state == S_OSC_OFF ? 1'b0 : oscControl[OSC_ENABLE_BIT];
            pumpClockSelect <= state == S_OSC_OFF ? 1'b0 : oscControl[PUMP_SELECT_BIT];
        end
    end

    // Argument register; the returned status wins over a software write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            argument <= ARGUMENT_RESET;
        end else if (state == S_FINISH && fromRequest) begin
            argument[STATUS_LSB +: 4] <= resultCode;
        end else if (writeArgument) begin
            argument <= regWdata;
        end
    end

    // Request register; completion clears the trigger bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            request <= REQUEST_RESET;
        end else if (state == S_FINISH && fromRequest) begin
            request[REQUEST_TRIGGER_BIT] <= 1'b0;
        end else if (writeRequest && !request[REQUEST_TRIGGER_BIT]) begin
            request <= regWdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastResult <= STATUS_SUCCESS;
        end else if (state == S_FINISH) begin
            lastResult <= resultCode;
        end
    end

    // Register read port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                REG_ARGUMENT: regRdata <= argument;
                REG_REQUEST: regRdata <= request;
                REG_OSC_CONTROL: regRdata <= {30'h0, oscControl};
                REG_STATUS: regRdata <= {20'h0, lastResult, state, 2'h0, erasePending, state != S_IDLE};
                default: regRdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : flash_row_write_erase_syscall

/* flash_row_write_erase_syscall_checker.sv */
// Concurrent checks on the ports of the flash system-call sequencer
`timescale 1ns/1ps
module flash_row_write_erase_syscall_checker
    import flash_syscall_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic sramReq, // Parameter read request
    input wire logic [31:0] sramAddr, // Parameter address
    input wire logic [7:0] chipProtection, // Chip protection mode
    input wire logic rowProtected, // Row write protected
    input wire flash_cmd_t flashCmd, // Flash command
    input wire latch_byte_t programByte, // Row data stream
    input wire logic fastOscOutputEnable // Fast oscillator enable
);
    logic [7:0] runCnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Length of the current run of streamed bytes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            runCnt <= 8'h00;
        end else begin
            runCnt <= programByte.valid ? runCnt + 8'h01 : 8'h00;
        end
    end
    a_start_single: assert property (flashCmd.start |=> !flashCmd.start)
        else $error("flash start longer than one cycle");
    a_param_aligned: assert property (sramReq |-> sramAddr[1:0] == 2'b00 ##1 $stable(sramAddr))
        else $error("parameter address not aligned or not held");
    a_osc_off_erase: assert property (flashCmd.start && flashCmd.op == FLASH_ERASE_ROW |-> !fastOscOutputEnable)
        else $error("row erased with fast oscillator on");
    a_stream_full_row: assert property ($fell(programByte.valid) |-> runCnt == 8'h80)
        else $error("row stream not 128 bytes");
    a_program_follows: assert property ($fell(programByte.valid) |->
        ##[0:2] (flashCmd.start && flashCmd.op == FLASH_PROGRAM_ROW))
        else $error("no program command after stream");
    a_no_empty_program: assert property (flashCmd.start && flashCmd.op == FLASH_PROGRAM_ROW |->
        $past(programByte.valid, 1) || $past(programByte.valid, 2))
        else $error("program command without data stream");
    a_protected_kept: assert property (flashCmd.start && flashCmd.op != FLASH_ERASE_ALL |-> !rowProtected)
        else $error("protected row altered");
    a_erase_all_open: assert property (flashCmd.start && flashCmd.op == FLASH_ERASE_ALL |->
        chipProtection == PROTECTION_OPEN)
        else $error("erase all while chip not open");
endmodule : flash_row_write_erase_syscall_checker
bind flash_row_write_erase_syscall flash_row_write_erase_syscall_checker chk_u (.ref_clk, .rst_n, .sramReq,
    .sramAddr, .chipProtection, .rowProtected, .flashCmd, .programByte, .fastOscOutputEnable);

/* flash_partner.sv */
// Caller-side SRAM and flash array model answering the sequencer
`timescale 1ns/1ps
module flash_partner
    import flash_syscall_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sramReq, // Parameter read request
    input wire logic [31:0] paramWord, // Word held in SRAM
    input wire flash_cmd_t flashCmd, // Flash command
    input wire logic slow, // Answer late
    output logic sramValid, // Word valid
    output logic [31:0] sramRdata, // Word data
    output logic flashDone // Operation done
);
    int sCnt = 0;
    int fCnt = 0;
    always @(posedge ref_clk) begin
        sCnt <= sramReq ? (slow ? 9 : 1) : (sCnt > 0 ? sCnt - 1 : 0);
        fCnt <= flashCmd.start ? (slow ? 20 : 2) : (fCnt > 0 ? fCnt - 1 : 0);
    end
    assign sramValid = (sCnt == 1);
    // Inverse off the valid cycle
    assign sramRdata = sramValid ? paramWord : ~paramWord;
    assign flashDone = (fCnt == 1);
endmodule : flash_partner

/* tb_flash_row_write_erase_syscall.sv */
// Self-checking testbench of the flash system-call sequencer
`timescale 1ns/1ps
module tb_flash_row_write_erase_syscall;
    import flash_syscall_pkg::*;
    logic ref_clk;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic sramReq, sramValid, flashDone, fastOscOutputEnable, pumpClockSelect;
    logic [31:0] sramAddr, sramRdata;
    logic [31:0] paramWord = 32'h0;
    logic slow = 1'b0;
    logic callerIsDebug = 1'b0;
    logic programmingMode = 1'b0;
    logic [7:0] chipProtection = PROTECTION_OPEN;
    logic rowProtected = 1'b0;
    logic latchLoadEn = 1'b0;
    logic [6:0] latchLoadIndex = 7'h0;
    logic [7:0] latchLoadData = 8'h0;
    flash_cmd_t flashCmd;
    latch_byte_t programByte;
    logic [7:0] expLatch [128] = '{default: 8'h00};
    int nOp [4];
    logic [15:0] rowSeen;
    int nMismatch = 0;
    int nChecks = 0;
    flash_row_write_erase_syscall dut_u (.ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .sramReq, .sramAddr, .sramValid, .sramRdata, .callerIsDebug, .programmingMode, .chipProtection,
        .rowProtected, .latchLoadEn, .latchLoadIndex, .latchLoadData, .flashCmd, .flashDone, .programByte,
        .fastOscOutputEnable, .pumpClockSelect);
    flash_partner part_u (.ref_clk, .sramReq, .paramWord, .flashCmd, .slow, .sramValid, .sramRdata, .flashDone);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // Flash commands seen and streamed bytes against the loaded latch
    always @(posedge ref_clk) begin
        if (flashCmd.start) begin
            nOp[flashCmd.op]++;
            rowSeen = flashCmd.row;
        end
        if (programByte.valid) chk(programByte.data, expLatch[programByte.index]);
        if (sramReq) chk(sramAddr, 32'h104);
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 q = regRdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic fill(input int first, input logic [7:0] v);
        for (int i = first; i < 128; i++) begin
            latchLoadEn <= 1'b1;
            latchLoadIndex <= 7'(i);
            latchLoadData <= v ^ 8'(i);
            expLatch[i] = v ^ 8'(i);
            @(posedge ref_clk);
        end
        latchLoadEn <= 1'b0;
        @(posedge ref_clk);
    endtask : fill
    task automatic call(input logic [15:0] op, input logic [7:0] k2, input logic [15:0] row, input logic [3:0] st);
        logic [31:0] q;
        nOp = '{default: 0};
        paramWord <= {row, k2, FIRST_KEY};
        wr(REG_ARGUMENT, 32'h0000_0104);
        wr(REG_REQUEST, {16'h8000, op});
        q = 32'hffff_ffff;
        for (int i = 0; i < 400 && q[31]; i++) rd(REG_REQUEST, q);
        chk(q[31], 1'b0);
        if (q[31]) complete_run();
        rd(REG_ARGUMENT, q);
        chk(q[31:28], st);
        if (st == STATUS_SUCCESS) expLatch = '{default: 8'h00};
    endtask : call
    task automatic s_reset();
        logic [31:0] q;
        rd(REG_ARGUMENT, q);
        chk(q, ARGUMENT_RESET);
        rd(REG_OSC_CONTROL, q);
        chk(q, 32'h1);
        rd(4'h2, q);
        chk(q, 32'h0);
    endtask : s_reset
    task automatic s_write_row();
        logic [31:0] q;
        fill(0, 8'h01);
        call(OPCODE_WRITE_ROW, SECOND_KEY_WRITE_ROW, 16'h0000, STATUS_SUCCESS);
        chk(nOp[1], 1);
        chk(nOp[2], 1);
        chk(rowSeen, 16'h0000);
        rd(REG_OSC_CONTROL, q);
        chk(q[1:0], 2'b00);
        wr(REG_OSC_CONTROL, 32'h3);
        @(posedge ref_clk);
        chk({pumpClockSelect, fastOscOutputEnable}, 2'b11);
    endtask : s_write_row
    task automatic s_skip_empty();
        call(OPCODE_WRITE_ROW, SECOND_KEY_WRITE_ROW, 16'hffff, STATUS_SUCCESS);
        chk(nOp[1], 1);
        chk(nOp[2], 0);
        wr(REG_OSC_CONTROL, 32'h3);
    endtask : s_skip_empty
    task automatic s_program_row();
        slow <= 1'b1;
        fill(127, 8'h5a);
        call(OPCODE_PROGRAM_ROW, SECOND_KEY_PROGRAM_ROW, 16'h0123, STATUS_SUCCESS);
        chk(nOp[1], 0);
        chk(nOp[2], 1);
        chk(rowSeen, 16'h0123);
        chk(fastOscOutputEnable, 1'b1);
        slow <= 1'b0;
    endtask : s_program_row
    task automatic s_refused();
        rowProtected <= 1'b1;
        call(OPCODE_WRITE_ROW, SECOND_KEY_WRITE_ROW, 16'h0002, STATUS_FAILURE);
        chk(nOp[1] + nOp[2], 0);
        rowProtected <= 1'b0;
        call(OPCODE_WRITE_ROW, SECOND_KEY_PROGRAM_ROW, 16'h0002, STATUS_FAILURE);
        chk(nOp[1] + nOp[2], 0);
        call(OPCODE_ERASE_ALL, SECOND_KEY_ERASE_ALL, 16'h0000, STATUS_FAILURE);
        chk(nOp[3], 0);
    endtask : s_refused
    task automatic s_erase_all();
        callerIsDebug <= 1'b1;
        programmingMode <= 1'b1;
        chipProtection <= PROTECTION_PROTECTED;
        call(OPCODE_ERASE_ALL, SECOND_KEY_ERASE_ALL, 16'h0000, STATUS_FAILURE);
        chk(nOp[3], 0);
        nOp = '{default: 0};
        chipProtection <= PROTECTION_OPEN;
        for (int i = 0; i < 60 && nOp[3] == 0; i++) @(posedge ref_clk);
        chk(nOp[3], 1);
        if (!nOp[3]) complete_run();
        repeat (10) @(posedge ref_clk);
        call(OPCODE_ERASE_ALL, SECOND_KEY_ERASE_ALL, 16'h0000, STATUS_SUCCESS);
        chk(nOp[3], 1);
    endtask : s_erase_all
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        s_reset();
        s_write_row();
        s_skip_empty();
        s_program_row();
        s_refused();
        s_erase_all();
        complete_run();
    end
endmodule : tb_flash_row_write_erase_syscall
